/* File: src/tpp_pkg.sv */
// shared constants for the trace probe port configuration block
package tpp_pkg;
	// register offsets on the software port
	localparam logic [7:0] OFS_TRACE_CONFIG = 8'h00;
	localparam logic [7:0] OFS_TRACE_CONTROL_SECOND = 8'h04;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// trace_config_reg field positions (read only)
	localparam int CFG_MAX_LSB = 0;
	localparam int CFG_MIN_LSB = 4;
	localparam int CFG_WIDTH_LSB = 8;
	localparam int CFG_ATTACHED_BIT = 12;

	// trace_control_second_reg field positions
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_CAL_BIT = 1;
	localparam int CTL_RATIO_LSB = 4;
	localparam int CTL_EFF_RATIO_LSB = 8;

	// reset value and full ratio code range
	localparam logic [2:0] RATIO_RESET = 3'h3;
	localparam logic [2:0] RATIO_LOWEST = 3'h0;
	localparam logic [2:0] RATIO_HIGHEST = 3'h7;

	// trace clock ratio codes
	localparam logic [2:0] RATIO_1_1 = 3'h3;
	localparam logic [2:0] RATIO_1_2 = 3'h4;
	localparam logic [2:0] RATIO_1_4 = 3'h5;
	localparam logic [2:0] RATIO_1_6 = 3'h6;
	localparam logic [2:0] RATIO_1_8 = 3'h7;

	// half periods of the divided trace clock, in core cycles
	localparam logic [2:0] HALF_1_2 = 3'h1;
	localparam logic [2:0] HALF_1_4 = 3'h2;
	localparam logic [2:0] HALF_1_6 = 3'h3;
	localparam logic [2:0] HALF_1_8 = 3'h4;

	// probe width strap codes
	localparam logic [1:0] WIDTH_4 = 2'h0;
	localparam logic [1:0] WIDTH_8 = 2'h1;
	localparam logic [1:0] WIDTH_16 = 2'h2;
	localparam logic [1:0] WIDTH_NONE = 2'h3;

	// calibration pattern
	localparam logic [15:0] CAL_PATTERN_A = 16'haaaa;
	localparam logic [15:0] CAL_PATTERN_B = 16'h5555;
	localparam logic [15:0] MASK_4 = 16'h000f;
	localparam logic [15:0] MASK_8 = 16'h00ff;
	localparam logic [15:0] MASK_16 = 16'hffff;
endpackage : tpp_pkg

/* File: src/tpp_link_if.sv */
// link between the trace controller and the probe interface block
`timescale 1ns/1ns
interface tpp_link_if;
	logic [2:0] trace_clk_ratio_code;
	logic trace_clk_div;
	logic trace_enable_out;
	logic calibrate_out;
	logic [2:0] ratio_max_cap_in;
	logic [2:0] ratio_min_cap_in;
	logic [1:0] probe_width_strap;
	logic probe_block_attached;

	modport device (
		output trace_clk_ratio_code,
		output trace_clk_div,
		output trace_enable_out,
		output calibrate_out,
		input ratio_max_cap_in,
		input ratio_min_cap_in,
		input probe_width_strap,
		input probe_block_attached
	);

	modport probe (
		input trace_clk_ratio_code,
		input trace_clk_div,
		input trace_enable_out,
		input calibrate_out,
		output ratio_max_cap_in,
		output ratio_min_cap_in,
		output probe_width_strap,
		output probe_block_attached
	);
endinterface : tpp_link_if

/* File: src/tpp_probe_end.sv */
// probe interface block end: drives the straps, follows enable and calibrate
`timescale 1ns/1ns
module tpp_probe_end (
	input wire logic probe_clk,
	input wire logic rst_b,
	tpp_link_if.probe link,
	input wire logic [2:0] cfg_max_cap,
	input wire logic [2:0] cfg_min_cap,
	input wire logic [1:0] cfg_width,
	input wire logic cfg_attached,
	input wire logic cfg_multi_core,
	output logic probe_clk_running,
	output logic probe_out_clk,
	output logic cal_active,
	output logic [15:0] cal_pattern,
	output logic [2:0] ratio_seen
);
	logic [2:0] max_reg, max_next;
	logic [2:0] min_reg, min_next;
	logic [1:0] width_reg, width_next;
	logic attached_reg, attached_next;
	// synchronisers from the controller's clock
	logic en_s1_reg, en_s2_reg, cal_s1_reg, cal_s2_reg;
	logic multi_s1_reg, multi_s2_reg;
	logic [2:0] ratio_s1_reg, ratio_s2_reg, ratio_s3_reg;
	logic run_reg, run_next;
	logic oclk_reg, oclk_next;
	logic cal_reg, cal_next;
	logic [15:0] pat_reg, pat_next;
	logic [2:0] ratio_reg, ratio_next;
	logic [15:0] mask;

	always_comb begin
		// straps are registered user settings, held static by the bench
		max_next = cfg_max_cap;
		min_next = cfg_min_cap;
		width_next = cfg_width;
		attached_next = cfg_attached;
		run_next = en_s2_reg;
		oclk_next = en_s2_reg ? ~oclk_reg : 1'b0;
		// a single-controller probe leaves calibrate alone
		cal_next = en_s2_reg && cal_s2_reg && multi_s2_reg;
		case (width_reg)
			tpp_pkg::WIDTH_4: mask = tpp_pkg::MASK_4;
			tpp_pkg::WIDTH_8: mask = tpp_pkg::MASK_8;
			tpp_pkg::WIDTH_16: mask = tpp_pkg::MASK_16;
			default: mask = tpp_pkg::MASK_16;
		endcase
		if (cal_next) begin
			pat_next = ((pat_reg == (tpp_pkg::CAL_PATTERN_A & mask)) ?
				tpp_pkg::CAL_PATTERN_B : tpp_pkg::CAL_PATTERN_A) & mask;
		end else begin
			pat_next = 16'h0000;
		end
		// the code is multi-bit: accept it only once two samples agree
		ratio_next = (ratio_s2_reg == ratio_s3_reg) ? ratio_s3_reg : ratio_reg;
	end

	always_ff @(posedge probe_clk or negedge rst_b) begin
		if (!rst_b) begin
			max_reg <= 3'h0;
			min_reg <= 3'h7;
			width_reg <= 2'h3;
			attached_reg <= 1'b0;
			en_s1_reg <= 1'b0;
			en_s2_reg <= 1'b0;
			cal_s1_reg <= 1'b0;
			cal_s2_reg <= 1'b0;
			multi_s1_reg <= 1'b0;
			multi_s2_reg <= 1'b0;
			ratio_s1_reg <= 3'h0;
			ratio_s2_reg <= 3'h0;
			ratio_s3_reg <= 3'h0;
			run_reg <= 1'b0;
			oclk_reg <= 1'b0;
			cal_reg <= 1'b0;
			pat_reg <= 16'h0000;
			ratio_reg <= 3'h0;
		end else begin
			max_reg <= max_next;
			min_reg <= min_next;
			width_reg <= width_next;
			attached_reg <= attached_next;
			en_s1_reg <= link.trace_enable_out;
			en_s2_reg <= en_s1_reg;
			cal_s1_reg <= link.calibrate_out;
			cal_s2_reg <= cal_s1_reg;
			multi_s1_reg <= cfg_multi_core;
			multi_s2_reg <= multi_s1_reg;
			ratio_s1_reg <= link.trace_clk_ratio_code;
			ratio_s2_reg <= ratio_s1_reg;
			ratio_s3_reg <= ratio_s2_reg;
			run_reg <= run_next;
			oclk_reg <= oclk_next;
			cal_reg <= cal_next;
			pat_reg <= pat_next;
			ratio_reg <= ratio_next;
		end
	end

	assign link.ratio_max_cap_in = max_reg;
	assign link.ratio_min_cap_in = min_reg;
	assign link.probe_width_strap = width_reg;
	assign link.probe_block_attached = attached_reg;
	assign probe_clk_running = run_reg;
	assign probe_out_clk = oclk_reg;
	assign cal_active = cal_reg;
	assign cal_pattern = pat_reg;
	assign ratio_seen = ratio_reg;
endmodule : tpp_probe_end

/* File: src/tpp_trace_ctrl.sv */
// trace controller end: software registers, ratio clamp, trace clock divider
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module tpp_trace_ctrl (
	input wire logic ref_clk,
	input wire logic rst_b,
	tpp_link_if.device link,
	input wire logic [tpp_pkg::ADDR_W-1:0] sw_addr,
	input wire logic [tpp_pkg::DATA_W-1:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [tpp_pkg::DATA_W-1:0] sw_rdata
);
	// strap synchronisers: the straps come from the probe's clock domain
	logic [2:0] max_s1_reg, max_s2_reg;
	logic [2:0] min_s1_reg, min_s2_reg;
	logic [1:0] width_s1_reg, width_s2_reg;
	logic att_s1_reg, att_s2_reg;

	// control register state
	logic enable_reg, enable_next;
	logic cal_reg, cal_next;
	logic [2:0] ratio_prog_reg, ratio_prog_next;
	logic [tpp_pkg::DATA_W-1:0] rdata_reg, rdata_next;

	// link outputs
	logic [2:0] ratio_out_reg, ratio_out_next;
	logic tr_en_reg, tr_en_next;
	logic cal_out_reg, cal_out_next;

	// divider
	logic [2:0] div_cnt_reg, div_cnt_next;
	logic div_clk_reg, div_clk_next;
	logic [2:0] half;

	// effective bounds
	logic [2:0] lo_bound, hi_bound;
	logic [2:0] ratio_eff;
	logic [1:0] width_eff;
	logic [tpp_pkg::DATA_W-1:0] cfg_word, ctl_word;

	// straps may tear for a cycle when they move; they are static, so a settled copy follows
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			max_s1_reg <= 3'h0;
			max_s2_reg <= 3'h0;
			min_s1_reg <= 3'h0;
			min_s2_reg <= 3'h0;
			width_s1_reg <= 2'h0;
			width_s2_reg <= 2'h0;
			att_s1_reg <= 1'b0;
			att_s2_reg <= 1'b0;
		end else begin
			max_s1_reg <= link.ratio_max_cap_in;
			max_s2_reg <= max_s1_reg;
			min_s1_reg <= link.ratio_min_cap_in;
			min_s2_reg <= min_s1_reg;
			width_s1_reg <= link.probe_width_strap;
			width_s2_reg <= width_s1_reg;
			att_s1_reg <= link.probe_block_attached;
			att_s2_reg <= att_s1_reg;
		end
	end

	// bounds and effective code
	always_comb begin
		if (att_s2_reg) begin
			lo_bound = max_s2_reg;
			hi_bound = min_s2_reg;
			width_eff = width_s2_reg;
		end else begin
			// no probe: capability and width inputs are disregarded
			lo_bound = tpp_pkg::RATIO_LOWEST;
			hi_bound = tpp_pkg::RATIO_HIGHEST;
			width_eff = tpp_pkg::WIDTH_NONE;
		end
		// if a badly strapped probe crosses them, codes below the lower bound take it and all others the upper one
		if (ratio_prog_reg < lo_bound) begin
			ratio_eff = lo_bound;
		end else if (ratio_prog_reg > hi_bound) begin
			ratio_eff = hi_bound;
		end else begin
			ratio_eff = ratio_prog_reg;
		end
	end

	// software port and control register
	always_comb begin
		// config reads show reset straps until the synchronisers settle
		cfg_word = '0;
		cfg_word[tpp_pkg::CFG_MAX_LSB +: 3] = att_s2_reg ? max_s2_reg : 3'h0;
		cfg_word[tpp_pkg::CFG_MIN_LSB +: 3] = att_s2_reg ? min_s2_reg : 3'h0;
		cfg_word[tpp_pkg::CFG_WIDTH_LSB +: 2] = width_eff;
		cfg_word[tpp_pkg::CFG_ATTACHED_BIT] = att_s2_reg;
		ctl_word = '0;
		ctl_word[tpp_pkg::CTL_ENABLE_BIT] = enable_reg;
		ctl_word[tpp_pkg::CTL_CAL_BIT] = cal_reg;
		ctl_word[tpp_pkg::CTL_RATIO_LSB +: 3] = ratio_prog_reg;
		ctl_word[tpp_pkg::CTL_EFF_RATIO_LSB +: 3] = ratio_out_reg;

		// writes elsewhere, the config offset included, change nothing
		enable_next = enable_reg;
		cal_next = cal_reg;
		ratio_prog_next = ratio_prog_reg;
		if (sw_wr && sw_addr == tpp_pkg::OFS_TRACE_CONTROL_SECOND) begin
			enable_next = sw_wdata[tpp_pkg::CTL_ENABLE_BIT];
			cal_next = sw_wdata[tpp_pkg::CTL_CAL_BIT];
			ratio_prog_next = sw_wdata[tpp_pkg::CTL_RATIO_LSB +: 3];
		end

		// read data stands only in the cycle after the strobe
		rdata_next = '0;
		if (sw_rd) begin
			case (sw_addr)
				tpp_pkg::OFS_TRACE_CONFIG: rdata_next = cfg_word;
				tpp_pkg::OFS_TRACE_CONTROL_SECOND: rdata_next = ctl_word;
				default: rdata_next = '0;
			endcase
		end
	end

	// link outputs
	always_comb begin
		ratio_out_next = ratio_eff;
		// enable is only passed on while a probe is attached
		tr_en_next = enable_reg && att_s2_reg;
		// calibrate passes even with enable low; the probe gates it itself
		cal_out_next = cal_reg && att_s2_reg;
	end

	// trace clock divider for the ratios slower than the core clock
	always_comb begin
		// half period in core cycles; zero leaves the divider idle
		case (ratio_out_reg)
			tpp_pkg::RATIO_1_2: half = tpp_pkg::HALF_1_2;
			tpp_pkg::RATIO_1_4: half = tpp_pkg::HALF_1_4;
			tpp_pkg::RATIO_1_6: half = tpp_pkg::HALF_1_6;
			tpp_pkg::RATIO_1_8: half = tpp_pkg::HALF_1_8;
			default: half = 3'h0;
		endcase
		// 1:1 and faster need a multiplier at the probe; the divider idles low
		if (!tr_en_reg || half == 3'h0) begin
			div_cnt_next = 3'h0;
			div_clk_next = 1'b0;
		end else if (div_cnt_reg + 3'h1 >= half) begin
			div_cnt_next = 3'h0;
			div_clk_next = ~div_clk_reg;
		end else begin
			div_cnt_next = div_cnt_reg + 3'h1;
			div_clk_next = div_clk_reg;
		end
	end

	// control register and read data
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			enable_reg <= 1'b0;
			cal_reg <= 1'b0;
			ratio_prog_reg <= tpp_pkg::RATIO_RESET;
			rdata_reg <= '0;
		end else begin
			enable_reg <= enable_next;
			cal_reg <= cal_next;
			ratio_prog_reg <= ratio_prog_next;
			rdata_reg <= rdata_next;
		end
	end

	// link outputs leave straight from flops so the probe never sees a glitch
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ratio_out_reg <= tpp_pkg::RATIO_RESET;
			tr_en_reg <= 1'b0;
			cal_out_reg <= 1'b0;
		end else begin
			ratio_out_reg <= ratio_out_next;
			tr_en_reg <= tr_en_next;
			cal_out_reg <= cal_out_next;
		end
	end

	// counter and output toggle together so each half period is exact
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_reg <= 3'h0;
			div_clk_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_cnt_next;
			div_clk_reg <= div_clk_next;
		end
	end

	assign link.trace_clk_ratio_code = ratio_out_reg;
	assign link.trace_enable_out = tr_en_reg;
	assign link.calibrate_out = cal_out_reg;
	assign link.trace_clk_div = div_clk_reg;
	assign sw_rdata = rdata_reg;
endmodule : tpp_trace_ctrl

/* File: testbench/tpp_link_asserts.sv */
// concurrent checks on the trace link signals
`timescale 1ns/1ns
module tpp_link_asserts (
	input wire logic ref_clk,
	input wire logic probe_clk,
	input wire logic rst_b,
	input wire logic [2:0] trace_clk_ratio_code,
	input wire logic trace_clk_div,
	input wire logic trace_enable_out,
	input wire logic calibrate_out,
	input wire logic [2:0] ratio_max_cap_in,
	input wire logic [2:0] ratio_min_cap_in,
	input wire logic [1:0] probe_width_strap,
	input wire logic probe_block_attached
);
	logic [8:0] straps;
	logic [8:0] prev_reg;
	logic [2:0] age_reg;
	logic [2:0] age_next;
	assign straps = {ratio_max_cap_in, ratio_min_cap_in, probe_width_strap, probe_block_attached};
	// straps reach the core domain through flops, so judge them only once settled
	always_comb begin
		age_next = age_reg;
		if (straps != prev_reg)
			age_next = 3'h0;
		else if (age_reg != 3'h7)
			age_next = age_reg + 3'h1;
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_reg <= 9'h0;
			age_reg <= 3'h0;
		end else begin
			prev_reg <= straps;
			age_reg <= age_next;
		end
	end
	chk_ratio_bounds: assert property (@(posedge ref_clk) disable iff (!rst_b)
		age_reg == 3'h7 && probe_block_attached |->
		trace_clk_ratio_code >= ratio_max_cap_in && trace_clk_ratio_code <= ratio_min_cap_in) else $error("bounds");
	chk_enable_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		age_reg == 3'h7 && !probe_block_attached |-> !trace_enable_out) else $error("enable gate");
	chk_cal_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		age_reg == 3'h7 && !probe_block_attached |-> !calibrate_out) else $error("cal gate");
	chk_div_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!trace_enable_out [*2] |-> !trace_clk_div) else $error("div idle");
	chk_div_eighth: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(trace_clk_div) ##0 (trace_enable_out && trace_clk_ratio_code == 3'h7) [*5] |->
		!trace_clk_div && $past(trace_clk_div) && $past(trace_clk_div, 3)) else $error("div eighth");
	chk_div_fourth: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(trace_clk_div) ##0 (trace_enable_out && trace_clk_ratio_code == 3'h5) [*3] |->
		!trace_clk_div && $past(trace_clk_div)) else $error("div fourth");
	chk_div_none: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(trace_enable_out && trace_clk_ratio_code <= 3'h3) [*2] |-> !trace_clk_div) else $error("div none");
	chk_strap_static: assert property (@(posedge probe_clk) disable iff (!rst_b)
		$past(probe_block_attached) |-> $stable(probe_width_strap)) else $error("width moved");
endmodule : tpp_link_asserts

/* File: testbench/tb_trace_probe_port_config.sv */
// self-checking bench: trace controller and probe end across the link
`timescale 1ns/1ns
module tb_trace_probe_port_config;
	typedef struct packed {logic [2:0] mx, mn; logic [1:0] w; logic [2:0] prog, eff, half;} tpp_row_t;
	tpp_row_t rows [5] = '{'{3'h4, 3'h7, 2'h0, 3'h7, 3'h7, 3'h4}, '{3'h4, 3'h7, 2'h1, 3'h3, 3'h4, 3'h1},
		'{3'h5, 3'h6, 2'h2, 3'h7, 3'h6, 3'h3}, '{3'h5, 3'h6, 2'h3, 3'h5, 3'h5, 3'h2},
		'{3'h2, 3'h3, 2'h0, 3'h1, 3'h2, 3'h0}};
	logic ref_clk, probe_clk, rst_b, sw_wr, sw_rd, attached, multi, running, cal_act, dv;
	logic [7:0] sw_addr;
	logic [31:0] sw_wdata, sw_rdata, rd_data;
	logic [2:0] max_cap, min_cap;
	logic [2:0] seen;
	logic oclk, o;
	logic [1:0] width;
	logic [15:0] pat, p;
	int fails, checks_done, n;
	tpp_link_if u_tpp_link_if ();
	assign dv = u_tpp_link_if.trace_clk_div;
	tpp_trace_ctrl u_tpp_trace_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .link(u_tpp_link_if), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	tpp_probe_end u_tpp_probe_end (.probe_clk(probe_clk), .rst_b(rst_b), .link(u_tpp_link_if),
		.cfg_max_cap(max_cap), .cfg_min_cap(min_cap), .cfg_width(width), .cfg_attached(attached),
		.cfg_multi_core(multi), .probe_clk_running(running), .probe_out_clk(oclk), .cal_active(cal_act),
		.cal_pattern(pat), .ratio_seen(seen));
	tpp_link_asserts u_tpp_link_asserts (.ref_clk(ref_clk), .probe_clk(probe_clk), .rst_b(rst_b),
		.trace_clk_ratio_code(u_tpp_link_if.trace_clk_ratio_code), .trace_clk_div(dv),
		.trace_enable_out(u_tpp_link_if.trace_enable_out), .calibrate_out(u_tpp_link_if.calibrate_out),
		.ratio_max_cap_in(u_tpp_link_if.ratio_max_cap_in), .ratio_min_cap_in(u_tpp_link_if.ratio_min_cap_in),
		.probe_width_strap(u_tpp_link_if.probe_width_strap),
		.probe_block_attached(u_tpp_link_if.probe_block_attached));
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask : tick
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		#1;
		rd_data = sw_rdata;
	endtask : rd
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (8) tick();
	endtask : do_reset
	// waits are bounded so a stuck divider shows as a wrong count, not a hang
	task automatic half_len(output int h);
		h = 0;
		repeat (40) if (dv) tick();
		repeat (40) if (!dv) tick();
		while (dv && h < 20) begin
			tick();
			h++;
		end
	endtask : half_len
	task automatic final_report();
		if (fails == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		probe_clk = 1'b0;
		#1;
		forever #3 probe_clk = ~probe_clk;
	end
	initial begin
		#100000;
		fails++;
		final_report();
	end
	initial begin
		{rst_b, sw_wr, sw_rd, sw_addr, sw_wdata, multi, max_cap} = '0;
		{min_cap, width, attached, fails, checks_done} = {3'h7, 2'h3, 1'b1, 64'h0};
		do_reset();
		rd(8'h04);
		chk("reset control", 32'h330, rd_data);
		tick();
		chk("rdata after", 32'h0, sw_rdata);
		foreach (rows[i]) begin
			@(posedge ref_clk);
			{max_cap, min_cap, width} <= {rows[i].mx, rows[i].mn, rows[i].w};
			do_reset();
			rd(8'h00);
			chk("config", {20'h1, 2'h0, rows[i].w, 1'b0, rows[i].mn, 1'b0, rows[i].mx}, rd_data);
			wr(8'h04, {25'h0, rows[i].prog, 4'h1});
			repeat (3) tick();
			rd(8'h04);
			chk("control", {21'h0, rows[i].eff, 1'b0, rows[i].prog, 4'h1}, rd_data);
			chk("code", {29'h0, rows[i].eff}, {29'h0, u_tpp_link_if.trace_clk_ratio_code});
			chk("ratio seen", {29'h0, rows[i].eff}, {29'h0, seen});
			if (rows[i].half != 3'h0)
				half_len(n);
			chk("half", {29'h0, rows[i].half}, n);
			n = 0;
			wr(8'h04, 32'h0);
		end
		multi <= 1'b1;
		wr(8'h04, 32'h73);
		repeat (20) tick();
		chk("cal out", 32'h1, {31'h0, u_tpp_link_if.calibrate_out});
		chk("running", 32'h1, {31'h0, running});
		chk("cal active", 32'h1, {31'h0, cal_act});
		chk("pattern", 32'h1, {31'h0, pat === 16'h000a || pat === 16'h0005});
		@(posedge probe_clk);
		#1;
		p = pat;
		o = oclk;
		@(posedge probe_clk);
		#1;
		chk("pattern step", {16'h0, p ^ 16'h000f}, {16'h0, pat});
		chk("probe clock", {31'h0, ~o}, {31'h0, oclk});
		@(posedge ref_clk);
		multi <= 1'b0;
		repeat (10) tick();
		chk("cal ignored", 32'h0, {31'h0, cal_act});
		wr(8'h04, 32'h0);
		repeat (20) tick();
		chk("stopped", 32'h0, {29'h0, running, oclk, u_tpp_link_if.calibrate_out});
		wr(8'h00, 32'hffffffff);
		rd(8'h00);
		chk("config ro", 32'h1032, rd_data);
		rd(8'h08);
		chk("unmapped", 32'h0, rd_data);
		@(posedge ref_clk);
		{attached, width} <= {1'b0, 2'h3};
		do_reset();
		rd(8'h04);
		chk("reset again", 32'h330, rd_data);
		wr(8'h04, 32'h73);
		repeat (5) tick();
		rd(8'h00);
		chk("detached config", 32'h300, rd_data);
		chk("detached out", 32'h0, {30'h0, u_tpp_link_if.trace_enable_out, u_tpp_link_if.calibrate_out});
		final_report();
	end
endmodule : tb_trace_probe_port_config
